// ==== src/data_word_mem.sv ====
// Data memory with registered read data
`timescale 1ns/10ps
module data_word_mem #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 16
) (
  input wire logic ref_clk,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data
);
  logic [DATA_W-1:0] mem [2**ADDR_W];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule : data_word_mem

// ==== src/dsp_exec_pkg.sv ====
// Package with encodings, widths and states for the execution block
package dsp_exec_pkg;
  localparam int DATA_W = 16;
  localparam int ACC_W = 32;
  localparam int DADDR_W = 7;
  localparam int EXT_ADDR_W = 12;
  localparam int PORT_W = 3;
  localparam int SHIFT_W = 4;
  localparam int CONST_W = 8;
  // Opcode patterns (instruction word, 16 bits)
  localparam logic [15:0] OP_INT_ENABLE = 16'h7F82;
  localparam logic [15:0] OP_INT_DISABLE = 16'h7F81;
  localparam logic [6:0] OP_COPY_HI = 7'h34;
  localparam logic [3:0] OP_LOAD_SHIFT_HI = 4'h2;
  localparam logic [7:0] OP_LOAD_CONST_HI = 8'h7E;
  localparam logic [4:0] OP_PORT_IN_HI = 5'h08;
  // Field positions
  localparam int SHIFT_LSB = 8;
  localparam int PORT_LSB = 8;
  // Reset value of the interrupt mode flag (interrupts blocked)
  localparam logic INT_MODE_RESET = 1'b1;
  typedef enum logic [2:0] {
    ST_IDLE, ST_COPY_WR, ST_LOAD_RD, ST_PORT_STROBE, ST_PORT_STORE
  } exec_state_t;
endpackage : dsp_exec_pkg

// ==== src/dsp_move_int_io_load_ops.sv ====
// Execution of data move, interrupt mode, port input and accumulator loads
// Functional notes
// - Copy data word to next higher address
// - Enable op clears interrupt mode flag
// - Maskable interrupts accepted only when flag clear
// - Disable op sets interrupt mode flag
// - Port address on low three lines
// - Data enable low in first port cycle
// - Memory enable high while data enable low
// - Short constant loads low eight accumulator bits
// - Short constant clears upper 24 bits
`timescale 1ns/10ps
module dsp_move_int_io_load_ops
  import dsp_exec_pkg::*;
#(
  parameter int DADDR_BITS = 7
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  output logic instr_done,
  input wire logic int_request,
  output logic int_accept,
  output logic int_mode_flag,
  output logic [dsp_exec_pkg::ACC_W-1:0] acc,
  output logic [dsp_exec_pkg::EXT_ADDR_W-1:0] ext_addr,
  input wire logic [dsp_exec_pkg::DATA_W-1:0] ext_data_in,
  output logic data_enable_strobe_b,
  output logic memory_enable_strobe_b,
  input wire logic mem_load_en,
  input wire logic [DADDR_BITS-1:0] mem_load_addr,
  input wire logic [dsp_exec_pkg::DATA_W-1:0] mem_load_data,
  input wire logic [DADDR_BITS-1:0] mem_peek_addr,
  output logic [dsp_exec_pkg::DATA_W-1:0] mem_peek_data
);
  import dsp_exec_pkg::*;

  exec_state_t state;
  logic [DADDR_BITS-1:0] op_addr;
  logic [SHIFT_W-1:0] op_shift;
  logic [DATA_W-1:0] rd_data;
  logic wr_en;
  logic [DADDR_BITS-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DADDR_BITS-1:0] rd_addr;
  logic [DATA_W-1:0] port_word;
  logic take;
  logic is_copy;
  logic is_load_shift;
  logic is_load_const;
  logic is_port_in;
  logic [ACC_W-1:0] shifted;
  logic [2:0] int_req_sync;
  logic int_req_seen;

  assign instr_ready = (state == ST_IDLE);
  assign take = instr_valid && instr_ready;
  assign is_copy = (instr_word[15:9] == OP_COPY_HI) && instr_word[8]
                   && !instr_word[7];
  assign is_load_shift = (instr_word[15:12] == OP_LOAD_SHIFT_HI)
                         && !instr_word[7];
  assign is_load_const = (instr_word[15:8] == OP_LOAD_CONST_HI);
  assign is_port_in = (instr_word[15:11] == OP_PORT_IN_HI)
                      && !instr_word[7];

  assign rd_addr = take ? instr_word[DADDR_BITS-1:0] : mem_peek_addr;

  // Sign-extend data word then shift, low bits zero-filled
  assign shifted = ACC_W'(signed'(rd_data)) << op_shift;

  data_word_mem #(
    .ADDR_W(DADDR_BITS),
    .DATA_W(DATA_W)
  ) u_mem (
    .ref_clk(ref_clk),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  assign mem_peek_data = rd_data;

  // Memory writes: copy, port store, or preload
  always_comb begin
    wr_en = mem_load_en;
    wr_addr = mem_load_addr;
    wr_data = mem_load_data;
    if (state == ST_COPY_WR) begin
      wr_en = 1'b1;
      wr_addr = op_addr + DADDR_BITS'(1);
      wr_data = rd_data;
    end else if (state == ST_PORT_STORE) begin
      wr_en = 1'b1;
      wr_addr = op_addr;
      wr_data = port_word;
    end
  end

  // Sequencer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take && is_copy) begin
            state <= ST_COPY_WR;
          end else if (take && is_load_shift) begin
            state <= ST_LOAD_RD;
          end else if (take && is_port_in) begin
            state <= ST_PORT_STROBE;
          end
        end
        ST_PORT_STROBE: state <= ST_PORT_STORE;
        ST_COPY_WR, ST_LOAD_RD, ST_PORT_STORE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Operand capture
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      op_addr <= '0;
      op_shift <= '0;
    end else if (take) begin
      op_addr <= instr_word[DADDR_BITS-1:0];
      op_shift <= instr_word[SHIFT_LSB +: SHIFT_W];
    end
  end

  // Interrupt mode flag
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      int_mode_flag <= INT_MODE_RESET;
    end else if (take && instr_word == OP_INT_ENABLE) begin
      int_mode_flag <= 1'b0;
    end else if (take && instr_word == OP_INT_DISABLE) begin
      int_mode_flag <= 1'b1;
    end
  end

  // Interrupt pin filter: three flops, second and third must agree
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      int_req_sync <= '0;
    end else begin
      int_req_sync <= {int_req_sync[1:0], int_request};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      int_req_seen <= 1'b0;
    end else if (int_req_sync[1] == int_req_sync[2]) begin
      int_req_seen <= int_req_sync[2];
    end
  end

  // Sole global gate for maskable interrupts
  assign int_accept = int_req_seen && !int_mode_flag;

  // Accumulator
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc <= '0;
    end else if (take && is_load_const) begin
      acc <= {{(ACC_W-CONST_W){1'b0}},
              instr_word[CONST_W-1:0]};
    end else if (state == ST_LOAD_RD) begin
      acc <= shifted;
    end
  end

  // Port address, upper lines zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_addr <= '0;
    end else if (take && is_port_in) begin
      ext_addr <= {{(EXT_ADDR_W-PORT_W){1'b0}},
                   instr_word[PORT_LSB +: PORT_W]};
    end
  end

  // Data enable low for the first port cycle only
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_enable_strobe_b <= 1'b1;
    end else begin
      data_enable_strobe_b <= !(take && is_port_in);
    end
  end

  // Memory strobe idle high, never raced against the port strobe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      memory_enable_strobe_b <= 1'b1;
    end else begin
      memory_enable_strobe_b <= 1'b1;
    end
  end

  // Word taken at the edge that ends the strobe cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_word <= '0;
    end else if (state == ST_PORT_STROBE) begin
      port_word <= ext_data_in;
    end
  end

  // Completion pulse
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      instr_done <= 1'b0;
    end else begin
      instr_done <= (take && !is_copy && !is_load_shift && !is_port_in)
                    || state == ST_COPY_WR || state == ST_LOAD_RD
                    || state == ST_PORT_STORE;
    end
  end
endmodule : dsp_move_int_io_load_ops

// ==== test/dsp_exec_monitor.sv ====
// Checker for the execution block ports
`timescale 1ns/10ps
module dsp_exec_monitor
  import dsp_exec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic instr_ready,
  input wire logic instr_done,
  input wire logic int_request,
  input wire logic int_accept,
  input wire logic int_mode_flag,
  input wire logic [31:0] acc,
  input wire logic [11:0] ext_addr,
  input wire logic data_enable_strobe_b,
  input wire logic memory_enable_strobe_b
);
  logic take;
  assign take = instr_valid && instr_ready;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_enable_clears_flag: assert property (
    take && instr_word == OP_INT_ENABLE |=> !int_mode_flag)
    else $error("flag not cleared");
  a_disable_sets_flag: assert property (
    take && instr_word == OP_INT_DISABLE |=> int_mode_flag)
    else $error("flag not set");
  a_int_gate: assert property (
    int_accept |-> !int_mode_flag)
    else $error("interrupt taken while blocked");
  a_int_pass: assert property (
    int_request [*5] ##0 !int_mode_flag |-> int_accept)
    else $error("steady request not accepted");
  a_int_block: assert property (
    !int_request [*5] |-> !int_accept)
    else $error("accepted without request");
  a_port_cycle: assert property (
    take && instr_word[15:11] == OP_PORT_IN_HI && !instr_word[7]
    |=> !data_enable_strobe_b
    && ext_addr == {9'h000, $past(instr_word[10:8])}
    ##1 data_enable_strobe_b)
    else $error("port cycle wrong");
  a_port_high_zero: assert property (
    !data_enable_strobe_b |-> ext_addr[11:3] == 9'h000)
    else $error("upper address lines set");
  a_mem_idle: assert property (
    !data_enable_strobe_b |-> memory_enable_strobe_b)
    else $error("memory strobe active");
  a_const_load: assert property (
    take && instr_word[15:8] == OP_LOAD_CONST_HI
    |=> acc == {24'h000000, $past(instr_word[7:0])})
    else $error("constant load wrong");
  a_copy_done: assert property (
    take && instr_word[15:8] == {OP_COPY_HI, 1'b1} && !instr_word[7]
    |=> !instr_done ##1 instr_done)
    else $error("copy timing wrong");
  a_shift_done: assert property (
    take && instr_word[15:12] == OP_LOAD_SHIFT_HI && !instr_word[7]
    |=> ##1 instr_done)
    else $error("load late");
  c_enable: cover property (take && instr_word == OP_INT_ENABLE);
  c_port: cover property ($fell(data_enable_strobe_b));
  c_const: cover property (take && instr_word[15:8] == OP_LOAD_CONST_HI);
endmodule : dsp_exec_monitor
bind dsp_move_int_io_load_ops dsp_exec_monitor u_mon (
  .ref_clk(ref_clk),
  .rst_b(rst_b),
  .instr_valid(instr_valid),
  .instr_word(instr_word),
  .instr_ready(instr_ready),
  .instr_done(instr_done),
  .int_request(int_request),
  .int_accept(int_accept),
  .int_mode_flag(int_mode_flag),
  .acc(acc),
  .ext_addr(ext_addr),
  .data_enable_strobe_b(data_enable_strobe_b),
  .memory_enable_strobe_b(memory_enable_strobe_b)
);

// ==== test/port_periph_model.sv ====
// Peripheral on the port bus answering input cycles
`timescale 1ns/10ps
module port_periph_model (
  input wire logic ref_clk,
  input wire logic data_enable_strobe_b,
  input wire logic [11:0] ext_addr,
  output logic [15:0] ext_data_in
);
  logic [15:0] last;
  logic [15:0] word;
  assign word = 16'h5A30 ^ {13'h0000, ext_addr[2:0]};
  always_ff @(posedge ref_clk) if (!data_enable_strobe_b) last <= word;
  // Word only while strobed, else a changed value
  assign ext_data_in = data_enable_strobe_b ? ~last : word;
endmodule : port_periph_model

// ==== test/test_dsp_move_int_io_load_ops.sv ====
// Testbench for the execution block
`timescale 1ns/10ps
module test_dsp_move_int_io_load_ops;
  import dsp_exec_pkg::*;
  logic ref_clk = 1'b0, rst_b, instr_valid, instr_ready, instr_done;
  logic int_request, int_accept, int_mode_flag, mem_load_en;
  logic data_enable_strobe_b, memory_enable_strobe_b;
  logic [15:0] instr_word, ext_data_in, mem_load_data, mem_peek_data, d;
  logic [31:0] acc;
  logic [11:0] ext_addr;
  logic [6:0] mem_load_addr, mem_peek_addr, a;
  logic [7:0] k;
  logic [15:0] ref_mem [128];
  int mismatches = 0, num_checks = 0, i, e;
  always #2.5 ref_clk = ~ref_clk;
  dsp_move_int_io_load_ops u_dut (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .instr_ready(instr_ready),
    .instr_done(instr_done),
    .int_request(int_request),
    .int_accept(int_accept),
    .int_mode_flag(int_mode_flag),
    .acc(acc),
    .ext_addr(ext_addr),
    .ext_data_in(ext_data_in),
    .data_enable_strobe_b(data_enable_strobe_b),
    .memory_enable_strobe_b(memory_enable_strobe_b),
    .mem_load_en(mem_load_en),
    .mem_load_addr(mem_load_addr),
    .mem_load_data(mem_load_data),
    .mem_peek_addr(mem_peek_addr),
    .mem_peek_data(mem_peek_data)
  );
  port_periph_model u_periph (
    .ref_clk(ref_clk),
    .data_enable_strobe_b(data_enable_strobe_b),
    .ext_addr(ext_addr),
    .ext_data_in(ext_data_in)
  );
  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, seen);
      mismatches++;
    end
  endtask : check
  task automatic exec(input logic [15:0] w);
    int n;
    @(posedge ref_clk);
    #1 instr_valid = 1'b1;
    instr_word = w;
    @(posedge ref_clk);
    #1 instr_valid = 1'b0;
    n = 0;
    while (instr_done !== 1'b1 && n < 8) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (instr_done !== 1'b1) mismatches++;
  endtask : exec
  task automatic load(input logic [6:0] ad, input logic [15:0] dt);
    ref_mem[ad] = dt;
    mem_load_en = 1'b1;
    mem_load_addr = ad;
    mem_load_data = dt;
    @(posedge ref_clk);
    #1 mem_load_en = 1'b0;
  endtask : load
  task automatic peek(input logic [6:0] ad, input logic [15:0] exp);
    mem_peek_addr = ad;
    @(posedge ref_clk);
    #1 check("mem", mem_peek_data, exp);
  endtask : peek
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  initial begin
    #200000 mismatches++;
    close_out();
  end
  initial begin
    void'($urandom(32'hB921));
    {rst_b, instr_valid, int_request, mem_load_en} = 4'h0;
    {instr_word, mem_load_addr, mem_load_data, mem_peek_addr} = '0;
    repeat (8) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    check("flag", int_mode_flag, 1'b1);
    check("strobe", data_enable_strobe_b, 1'b1);
    for (i = 0; i < 6; i++) begin
      int_request = 1'($urandom);
      exec(i[0] ? OP_INT_DISABLE : OP_INT_ENABLE);
      check("flag", int_mode_flag, i[0]);
      repeat (3) @(posedge ref_clk);
      #1 check("accept", int_accept, int_request & !i[0]);
    end
    for (i = 0; i < 6; i++) begin
      k = (i == 0) ? 8'hFF : 8'($urandom);
      exec({OP_LOAD_CONST_HI, k});
      check("acc", acc, {24'h000000, k});
    end
    rst_b = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check("acc", acc, 32'h0000_0000);
    check("flag", int_mode_flag, 1'b1);
    rst_b = 1'b1;
    for (i = 0; i < 3; i++) begin
      a = (i == 0) ? 7'h7F : 7'($urandom_range(126));
      d = 16'($urandom);
      load(a, d);
      exec({OP_COPY_HI, 2'h2, a});
      ref_mem[a + 7'h01] = ref_mem[a];
      peek(a + 7'h01, ref_mem[a + 7'h01]);
      peek(a, ref_mem[a]);
    end
    for (i = 0; i < 16; i++) begin
      d = 16'($urandom);
      load(7'h10, d);
      exec({OP_LOAD_SHIFT_HI, i[3:0], 8'h10});
      e = int'($signed(d)) << i;
      check("acc", acc, e);
    end
    for (i = 0; i < 8; i++) begin
      exec({OP_PORT_IN_HI, i[2:0], 8'h20});
      ref_mem[7'h20] = 16'h5A30 ^ i[15:0];
      peek(7'h20, ref_mem[7'h20]);
    end
    close_out();
  end
endmodule : test_dsp_move_int_io_load_ops
